// file: gprc_bus_if.sv
`timescale 1ns/1ns
`default_nettype none
// byte-level bus: the handshake is abstracted into a one-cycle dav strobe
interface gprc_bus_if;
  logic       ren;
  logic       ifc;
  logic       atn;
  logic       dav;
  logic [7:0] dio;
  modport ctrl (output ren, output ifc, output atn, output dav, output dio);
  modport dev  (input ren, input ifc, input atn, input dav, input dio);
endinterface
`default_nettype wire

// file: gprc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module gprc_ctrl
  import gprc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  gprc_bus_if.ctrl         bus,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o
);

  // ------------------------------------------------------------
  // register slave
  // ------------------------------------------------------------
  typedef enum logic [2:0] {H_IDLE, H_ADDR, H_CMD, H_DONE, H_IFC} gprc_hst_e;
  gprc_hst_e   state;
  logic [4:0]  addr;
  logic [6:0]  cmd_byte;
  logic        need_cmd;
  logic [11:0] ifc_cnt;

  wire logic [1:0] reg_idx  = avs_address_i[3:2];
  wire logic       req      = avs_read_i | avs_write_i;
  wire logic       ctrl_wr  = avs_write_i & (reg_idx == REG_CTRL);
  // a new order waits in waitrequest until the previous sequence ends
  wire logic       stall    = ctrl_wr & (state != H_IDLE);
  wire logic       accept   = req & avs_waitrequest_o & ~stall;
  wire logic       start    = ctrl_wr & ~avs_waitrequest_o;
  wire logic [3:0] wr_op    = avs_writedata_i[CTRL_OP_LSB +: 4];
  wire logic [4:0] wr_addr  = avs_writedata_i[CTRL_ADDR_LSB +: 5];
  wire logic [31:0] status  = {19'h0, addr, 5'h0, bus.ifc, bus.ren, (state != H_IDLE)};
  wire logic [31:0] rd_data = (avs_read_i && reg_idx == REG_STATUS) ? status : 32'h0;

  // one wait cycle per unstalled access; data and the write take effect when it drops
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
    end else begin
      avs_waitrequest_o <= ~accept;
      avs_readdata_o    <= accept ? rd_data : avs_readdata_o;
    end
  end

  // ------------------------------------------------------------
  // bus sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state    <= H_IDLE;
      addr     <= ADDR_DEFAULT;
      cmd_byte <= 7'h0;
      need_cmd <= 1'b0;
      ifc_cnt  <= 12'h0;
      bus.ren  <= 1'b0;
      bus.ifc  <= 1'b0;
      bus.atn  <= 1'b0;
      bus.dav  <= 1'b0;
      bus.dio  <= 8'h0;
    end else begin
      bus.dav <= 1'b0;
      case (state)
        H_IDLE: begin
          if (start) begin
            addr     <= wr_addr;
            need_cmd <= 1'b1;
            case (wr_op)
              OP_REMOTE: begin
                bus.ren  <= 1'b1;
                need_cmd <= 1'b0;
                state    <= H_ADDR;
              end
              OP_IFC: begin
                bus.ifc <= 1'b1;
                ifc_cnt <= 12'h0;
                state   <= H_IFC;
              end
              OP_LLO: begin
                cmd_byte <= BYTE_LLO;
                state    <= H_CMD;
              end
              OP_DCL: begin
                cmd_byte <= BYTE_DCL;
                state    <= H_CMD;
              end
              OP_GTL: begin
                cmd_byte <= BYTE_GTL;
                state    <= H_ADDR;
              end
              OP_SDC: begin
                cmd_byte <= BYTE_SDC;
                state    <= H_ADDR;
              end
              OP_GET: begin
                cmd_byte <= BYTE_GET;
                state    <= H_ADDR;
              end
              OP_TALK: begin
                // own talk address unlistens the device, another one untalks it
                cmd_byte <= {GRP_TALK, wr_addr};
                state    <= H_CMD;
              end
              OP_LOCAL: begin
                bus.ren <= 1'b0;
              end
              default: begin
                need_cmd <= 1'b0;
              end
            endcase
          end
        end
        H_ADDR: begin
          bus.atn <= 1'b1;
          bus.dav <= 1'b1;
          bus.dio <= {1'b0, GRP_LISTEN, addr};
          state   <= need_cmd ? H_CMD : H_DONE;
        end
        H_CMD: begin
          bus.atn <= 1'b1;
          bus.dav <= 1'b1;
          bus.dio <= {1'b0, cmd_byte};
          state   <= H_DONE;
        end
        H_DONE: begin
          bus.atn <= 1'b0;
          state   <= H_IDLE;
        end
        H_IFC: begin
          // held for exactly the minimum; the count rounds the time up to whole cycles
          ifc_cnt <= ifc_cnt + 12'h1;
          if (ifc_cnt == IFC_LAST) begin
            bus.ifc <= 1'b0;
            state   <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: gprc_device.sv
// What this block does
// - remote only when addressed while remote-enable held
// - controller raises remote-enable before listen address
// - interface clear: local, talker and listener idle
// - controller holds interface clear 100 us
// - lockout blocks every panel key but power
// - lockout command honoured only with remote-enable
// - only remote-enable falling cancels lockout
// - controller sends lockout byte under attention
// - go-to-local while listening drops remote
// - controller addresses listener then sends go-to-local
// - universal clear acts without addressing
// - clears restore factory or user default set
// - controller sends universal clear under attention
// - selective clear acts only when listening
// - controller addresses listener then sends selective clear
// - trigger while listening starts reading in trigger modes
// - controller addresses listener then sends trigger
// - factory set: dc volts, top range, prefix, external
// - own addresses from configurable primary address
`timescale 1ns/1ns
`default_nettype none
module gprc_device
  import gprc_pkg::*;
#(
  parameter logic [4:0] PRIMARY_ADDR = gprc_pkg::ADDR_DEFAULT,
  parameter int         KEYS         = 8,
  parameter int         POWER_KEY    = 0
)(
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  gprc_bus_if.dev                   bus,
  input  wire logic                 addr_we_i,
  input  wire logic [4:0]           addr_i,
  input  wire logic                 set_we_i,
  input  wire gprc_pkg::gprc_set_s  set_i,
  input  wire logic                 user_sel_i,
  input  wire gprc_pkg::gprc_set_s  user_set_i,
  input  wire logic [KEYS-1:0]      keys_i,
  output logic [KEYS-1:0]           keys_o,
  output logic [4:0]                addr_o,
  output logic                      remote_o,
  output logic                      lockout_o,
  output logic                      talk_o,
  output logic                      listen_o,
  output gprc_pkg::gprc_set_s       settings_o,
  output logic                      clear_o,
  output logic                      trigger_o
);

  // ------------------------------------------------------------
  // byte decode
  // ------------------------------------------------------------
  logic [4:0] my_addr;
  logic       remote;
  logic       lockout;
  logic       talk;
  logic       listen;
  gprc_set_s  settings;
  logic [KEYS-1:0] keys_meta;
  logic [KEYS-1:0] keys_sync;

  // only bytes sent under attention are bus commands
  wire logic       cmd     = bus.dav & bus.atn;
  wire logic [6:0] byte7   = bus.dio[6:0];
  wire logic       is_mla  = cmd & (byte7 == {GRP_LISTEN, my_addr});
  wire logic       is_mta  = cmd & (byte7 == {GRP_TALK, my_addr});
  wire logic       is_ota  = cmd & (byte7[6:5] == GRP_TALK) & ~is_mta;
  wire logic       is_unl  = cmd & (byte7 == BYTE_UNL);
  wire logic       is_unt  = cmd & (byte7 == BYTE_UNT);
  wire logic       is_gtl  = cmd & (byte7 == BYTE_GTL) & listen;
  wire logic       is_sdc  = cmd & (byte7 == BYTE_SDC) & listen;
  wire logic       is_get  = cmd & (byte7 == BYTE_GET) & listen;
  wire logic       is_llo  = cmd & (byte7 == BYTE_LLO) & bus.ren;
  wire logic       is_dcl  = cmd & (byte7 == BYTE_DCL);
  wire logic       do_clr  = is_dcl | is_sdc;
  wire logic       bus_trg = (settings.trig == TRIG_MODE_SINGLE_ON_GET_A) |
                             (settings.trig == TRIG_MODE_SINGLE_ON_GET_B);

  // ------------------------------------------------------------
  // next-state terms
  // ------------------------------------------------------------
  logic next_remote;
  logic next_lockout;
  logic next_talk;
  logic next_listen;
  gprc_set_s next_settings;

  // remote: remote-enable alone is not enough, the listen address must follow
  always_comb begin
    next_remote = remote;
    if (!bus.ren || bus.ifc) begin
      next_remote = 1'b0;
    end else if (is_mla) begin
      next_remote = 1'b1;
    end else if (is_gtl) begin
      next_remote = 1'b0;
    end
  end

  // lockout survives go-to-local and interface clear; only ren low ends it
  always_comb begin
    next_lockout = lockout;
    if (!bus.ren) begin
      next_lockout = 1'b0;
    end else if (is_llo) begin
      next_lockout = 1'b1;
    end
  end

  // listener: unaddressed on unlisten or on own talk address
  always_comb begin
    next_listen = listen;
    if (bus.ifc) begin
      next_listen = 1'b0;
    end else if (is_mla) begin
      next_listen = 1'b1;
    end else if (is_unl || is_mta) begin
      next_listen = 1'b0;
    end
  end

  // talker: unaddressed on untalk, other talk address or own listen address
  always_comb begin
    next_talk = talk;
    if (bus.ifc) begin
      next_talk = 1'b0;
    end else if (is_mta) begin
      next_talk = 1'b1;
    end else if (is_unt || is_ota || is_mla) begin
      next_talk = 1'b0;
    end
  end

  // a clear outranks a same-cycle settings write so the default set wins
  always_comb begin
    next_settings = settings;
    if (do_clr) begin
      next_settings = user_sel_i ? user_set_i : FACTORY_SET;
    end else if (set_we_i) begin
      next_settings = set_i;
    end
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      remote   <= 1'b0;
      lockout  <= 1'b0;
      talk     <= 1'b0;
      listen   <= 1'b0;
      settings <= FACTORY_SET;
    end else begin
      remote   <= next_remote;
      lockout  <= next_lockout;
      talk     <= next_talk;
      listen   <= next_listen;
      settings <= next_settings;
    end
  end

  // primary address is configurable; reset restores the default
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      my_addr <= PRIMARY_ADDR;
    end else if (addr_we_i) begin
      my_addr <= addr_i;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // keys come from the panel pins, so they are synchronised first
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      keys_meta <= '0;
      keys_sync <= '0;
    end else begin
      keys_meta <= keys_i;
      keys_sync <= keys_meta;
    end
  end

  // power stays usable under lockout so the user can always switch off
  wire logic [KEYS-1:0] power_mask = KEYS'(1) << POWER_KEY;
  wire logic [KEYS-1:0] keys_pass  = lockout ? (keys_sync & power_mask) : keys_sync;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      keys_o     <= '0;
      addr_o     <= PRIMARY_ADDR;
      remote_o   <= 1'b0;
      lockout_o  <= 1'b0;
      talk_o     <= 1'b0;
      listen_o   <= 1'b0;
      settings_o <= FACTORY_SET;
      clear_o    <= 1'b0;
      trigger_o  <= 1'b0;
    end else begin
      keys_o     <= keys_pass;
      addr_o     <= my_addr;
      remote_o   <= next_remote;
      lockout_o  <= next_lockout;
      talk_o     <= next_talk;
      listen_o   <= next_listen;
      settings_o <= next_settings;
      clear_o    <= do_clr;
      trigger_o  <= is_get & bus_trg;
    end
  end

endmodule
`default_nettype wire

// file: gprc_pkg.sv
`default_nettype none
package gprc_pkg;
  // ------------------------------------------------------------
  // bus command bytes (low seven data lines)
  // ------------------------------------------------------------
  localparam logic [6:0] BYTE_GTL = 7'h01;
  localparam logic [6:0] BYTE_SDC = 7'h04;
  localparam logic [6:0] BYTE_GET = 7'h08;
  localparam logic [6:0] BYTE_LLO = 7'h11;
  localparam logic [6:0] BYTE_DCL = 7'h14;
  localparam logic [6:0] BYTE_UNL = 7'h3f;
  localparam logic [6:0] BYTE_UNT = 7'h5f;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK   = 2'h2;
  localparam logic [4:0] ADDR_DEFAULT = 5'h0a;

  // ------------------------------------------------------------
  // instrument settings and factory set
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] func;
    logic [3:0] range;
    logic [3:0] format;
    logic [3:0] trig;
  } gprc_set_s;
  localparam logic [3:0] FUNCTION_DC_VOLTS             = 4'h0;
  localparam logic [3:0] RANGE_TOP_SETTING             = 4'h5;
  localparam logic [3:0] FORMAT_WITH_PREFIX            = 4'h0;
  localparam logic [3:0] TRIG_MODE_SINGLE_ON_GET_A     = 4'h2;
  localparam logic [3:0] TRIG_MODE_SINGLE_ON_GET_B     = 4'h3;
  localparam logic [3:0] TRIG_MODE_CONTINUOUS_EXTERNAL = 4'h6;
  localparam gprc_set_s  FACTORY_SET = '{FUNCTION_DC_VOLTS, RANGE_TOP_SETTING,
                                         FORMAT_WITH_PREFIX, TRIG_MODE_CONTINUOUS_EXTERNAL};

  // ------------------------------------------------------------
  // controller registers and timing
  // ------------------------------------------------------------
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_ADDR_LSB = 8;
  localparam logic [3:0] OP_REMOTE = 4'h0;
  localparam logic [3:0] OP_IFC    = 4'h1;
  localparam logic [3:0] OP_LLO    = 4'h2;
  localparam logic [3:0] OP_GTL    = 4'h3;
  localparam logic [3:0] OP_DCL    = 4'h4;
  localparam logic [3:0] OP_SDC    = 4'h5;
  localparam logic [3:0] OP_GET    = 4'h6;
  localparam logic [3:0] OP_LOCAL  = 4'h7;
  localparam logic [3:0] OP_TALK   = 4'h8;  // talk address byte under attention
  localparam int CLK_PERIOD_NS = 40;
  localparam int IFC_TIME_NS   = 100000;
  localparam int IFC_CYCLES    = (IFC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] IFC_LAST = 12'(IFC_CYCLES - 1);
endpackage
`default_nettype wire

// file: gprc_sva.sv
`timescale 1ns/1ns
`default_nettype none
module gprc_sva
  import gprc_pkg::*;
(
  input wire logic                clk_i,
  input wire logic                srst_i,
  input wire logic                ren,
  input wire logic                ifc,
  input wire logic                atn,
  input wire logic                dav,
  input wire logic [7:0]          dio,
  input wire logic [4:0]          addr_o,
  input wire logic                remote_o,
  input wire logic                lockout_o,
  input wire logic                talk_o,
  input wire logic                listen_o,
  input wire gprc_pkg::gprc_set_s settings_o,
  input wire logic                clear_o,
  input wire logic                trigger_o
);
  logic [11:0] ifc_cnt;
  // ----------------------------------------
  // decoded command bytes
  // ----------------------------------------
  wire cmd = atn & dav;
  wire [6:0] cb = dio[6:0];
  wire bus_mode = (settings_o.trig == TRIG_MODE_SINGLE_ON_GET_A)
                | (settings_o.trig == TRIG_MODE_SINGLE_ON_GET_B);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // clear-line width; saturates so a stuck line cannot wrap
  always_ff @(posedge clk_i) begin
    if (srst_i || !ifc)
      ifc_cnt <= '0;
    else if (ifc_cnt != 12'hfff)
      ifc_cnt <= ifc_cnt + 12'h1;
  end
  a_ifc_min_width: assert property ($fell(ifc) |-> ifc_cnt > IFC_LAST)
    else $error("interface clear too short");
  a_ifc_idles_all: assert property (ifc |=> !remote_o && !talk_o && !listen_o)
    else $error("interface clear left state active");
  a_remote_needs_mla: assert property ($rose(remote_o) |-> $past(ren && cmd && cb == {GRP_LISTEN, addr_o}))
    else $error("remote without listen address");
  a_lockout_needs_ren: assert property ($rose(lockout_o) |-> $past(ren && cmd && cb == BYTE_LLO))
    else $error("lockout without lockout byte and ren");
  a_ren_low_unlocks: assert property (!ren |=> !lockout_o && !remote_o)
    else $error("lockout kept with ren low");
  a_gtl_keeps_lock: assert property (lockout_o && ren && !ifc && cmd && cb == BYTE_GTL |=> lockout_o)
    else $error("go-to-local cancelled lockout");
  a_gtl_drops_remote: assert property (listen_o && cmd && cb == BYTE_GTL |=> !remote_o)
    else $error("go-to-local kept remote");
  a_dcl_clears: assert property (cmd && cb == BYTE_DCL |=> clear_o)
    else $error("universal clear not acted on");
  a_sdc_unaddressed: assert property (!listen_o && cmd && cb == BYTE_SDC |=> !clear_o)
    else $error("selective clear while not listening");
  a_get_mode_gate: assert property (listen_o && cmd && cb == BYTE_GET |=> trigger_o == $past(bus_mode))
    else $error("trigger against trigger mode");
  a_dav_under_atn: assert property (dav |-> atn)
    else $error("command byte without attention");
  a_talk_on_mta: assert property (cmd && !ifc && cb == {GRP_TALK, addr_o} |=> talk_o && !listen_o)
    else $error("own talk address not honoured");
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import gprc_pkg::*;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [3:0]  av_addr = 4'h0;
  logic        av_rd = 1'b0;
  logic        av_wr = 1'b0;
  logic [31:0] av_wd = 32'h0;
  logic [31:0] av_rdat;
  logic        av_wait;
  logic        addr_we = 1'b0;
  logic        set_we = 1'b0;
  logic        user_sel = 1'b0;
  gprc_set_s   set_val = FACTORY_SET;
  gprc_set_s   user_set = 16'h3113;
  gprc_set_s   settings;
  logic [7:0]  keys = 8'hff;
  logic [7:0]  keys_out;
  logic [4:0]  addr_out;
  logic        remote, lockout, talk, listen, clr, trig;
  logic [31:0] rd;
  logic [3:0]  modes [4] = '{4'h2, 4'h3, 4'h6, 4'h0};
  int          fails = 0;
  int          samples_checked = 0;
  int          n_clr = 0;
  int          n_trig = 0;
  int          c;
  gprc_bus_if bus ();
  gprc_ctrl gprc_ctrl_inst (.clk_i(clk_i), .srst_i(srst_i), .bus(bus.ctrl), .avs_address_i(av_addr),
    .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wd), .avs_readdata_o(av_rdat),
    .avs_waitrequest_o(av_wait));
  gprc_device gprc_device_inst (.clk_i(clk_i), .srst_i(srst_i), .bus(bus.dev), .addr_we_i(addr_we),
    .addr_i(5'h07), .set_we_i(set_we), .set_i(set_val), .user_sel_i(user_sel), .user_set_i(user_set),
    .keys_i(keys), .keys_o(keys_out), .addr_o(addr_out), .remote_o(remote), .lockout_o(lockout),
    .talk_o(talk), .listen_o(listen), .settings_o(settings), .clear_o(clr), .trigger_o(trig));
  gprc_sva gprc_sva_inst (.clk_i(clk_i), .srst_i(srst_i), .ren(bus.ren), .ifc(bus.ifc), .atn(bus.atn),
    .dav(bus.dav), .dio(bus.dio), .addr_o(addr_out), .remote_o(remote), .lockout_o(lockout),
    .talk_o(talk), .listen_o(listen), .settings_o(settings), .clear_o(clr), .trigger_o(trig));
  always #20 clk_i = ~clk_i;
  // pulse counters, so a one-cycle output is never missed
  always @(posedge clk_i) begin
    if (clr === 1'b1) n_clr <= n_clr + 1;
    if (trig === 1'b1) n_trig <= n_trig + 1;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tmo();
    fails++;
    give_verdict();
  endtask
  // one avalon access; held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    av_addr <= a;
    av_wd <= d;
    av_wr <= wr;
    av_rd <= !wr;
    for (i = 0; i < 4000; i++) begin
      @(posedge clk_i);
      if (av_wait === 1'b0) break;
    end
    rd = av_rdat;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk_i);
    if (i == 4000) tmo();
  endtask
  // issue a controller order, then poll busy until the sequence is over
  task automatic op(input logic [3:0] code, input logic [4:0] a);
    int i;
    av(1'b1, {REG_CTRL, 2'b00}, {19'h0, a, 4'h0, code});
    for (i = 0; i < 2000; i++) begin
      av(1'b0, {REG_STATUS, 2'b00}, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (i == 2000) tmo();
  endtask
  task automatic ld_set(input gprc_set_s s);
    set_val <= s;
    set_we <= 1'b1;
    @(posedge clk_i);
    set_we <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    chk("flags", {remote, lockout, talk, listen}, 4'h0);
    chk("addr", addr_out, 5'h0a);
    chk("settings", settings, FACTORY_SET);
    $display("reset test done");
    addr_we <= 1'b1;
    @(posedge clk_i);
    addr_we <= 1'b0;
    // address register, then its output flop: two edges before it shows
    repeat (2) @(posedge clk_i);
    chk("addr", addr_out, 5'h07);
    op(OP_REMOTE, 5'h0a);
    chk("remote_listen", {remote, listen}, 2'h0);
    chk("ren", rd[1], 1'b1);
    op(OP_REMOTE, 5'h07);
    chk("remote_listen", {remote, listen}, 2'h3);
    $display("remote test done");
    op(OP_LLO, 5'h07);
    chk("lockout", lockout, 1'b1);
    repeat (4) @(posedge clk_i);
    chk("keys", keys_out, 8'h01);
    op(OP_GTL, 5'h07);
    chk("remote_lockout", {remote, lockout}, 2'h1);
    op(OP_LOCAL, 5'h07);
    chk("lockout", lockout, 1'b0);
    repeat (4) @(posedge clk_i);
    chk("keys", keys_out, 8'hff);
    op(OP_LLO, 5'h07);
    chk("lockout", lockout, 1'b0);
    $display("lockout test done");
    op(OP_REMOTE, 5'h07);
    op(OP_TALK, 5'h07);
    chk("talk_listen", {talk, listen}, 2'h2);
    op(OP_IFC, 5'h07);
    chk("idle", {remote, talk, listen}, 3'h0);
    $display("clear line test done");
    ld_set(16'h1232);
    op(OP_SDC, 5'h03);
    chk("settings", settings, 16'h1232);
    op(OP_DCL, 5'h03);
    chk("settings", settings, FACTORY_SET);
    user_sel <= 1'b1;
    op(OP_SDC, 5'h07);
    chk("settings", settings, user_set);
    chk("clears", 16'(n_clr), 16'h2);
    $display("device clear test done");
    for (int k = 0; k < 4; k++) begin
      ld_set({4'h0, 4'h5, 4'h0, modes[k]});
      c = n_trig;
      op(OP_GET, 5'h07);
      chk("trigger", 16'(n_trig - c), 16'(k < 2));
    end
    $display("trigger test done");
    av(1'b1, 4'hc, 32'h6);
    av(1'b0, 4'hc, 32'h0);
    chk("unmapped", rd[15:0], 16'h0);
    $display("register test done");
    give_verdict();
  end
endmodule
`default_nettype wire
